// ### inc/sir_pkg.sv
// constants and types shared by the system integration status register bank
package sir_pkg;
  // register addresses on the internal address bus
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] ADDR_BREAK_FLAG_CTRL = 16'hFE03;
  localparam logic [15:0] ADDR_IRQ_LOW = 16'hFE04;
  localparam logic [15:0] ADDR_IRQ_HIGH = 16'hFE05;

  // field positions
  localparam int BIT_BREAK_WAIT = 1;
  localparam int BIT_CLEAR_ENABLE = 7;
  localparam int IRQ_LOW_SHIFT = 2;
  localparam int IRQ_LOW_COUNT = 6;
  localparam int IRQ_HIGH_COUNT = 8;
  localparam int IRQ_DOC_COUNT = 14;
  localparam int IRQ_MAX_COUNT = 128;

  // reset values
  localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // clock division ratios relative to the doubled clock
  localparam int DIV_CRYSTAL = 2;
  localparam int DIV_BUS = 4;

  // reset cause flags, bit 7 down to bit 1, bit 0 always reads 0
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_address;
    logic usb;
    logic low_voltage;
    logic zero;
  } sir_reset_cause_s;

  // internal bus request from the cpu core
  typedef struct packed {
    logic strobe;
    logic read_not_write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sir_bus_req_s;
endpackage

// ### hw/sir_clk_div.sv
// divider of the doubled clock giving a one-cycle tick and a square wave
`timescale 1ns/1ns
module sir_clk_div #(
  parameter int DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic tick_q,
  output logic square_q
);
  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_d;
  logic square_d;

  // free running count, never gated by any mode
  always_comb
  begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    tick_d = (cnt_d == LAST);
    square_d = (cnt_d >= HALF);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
      square_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      square_q <= square_d;
    end
  end
endmodule // sir_clk_div

// ### hw/sir_status_regs.sv
// status and control register bank of the system integration unit
`timescale 1ns/1ns
// Behaviour
// - The crystal clock output keeps toggling without a break while the chip sits in the break state.
// - The bus clock is the doubled clock divided by four, that is half the crystal clock.
// - The break wait flag is bit 1 of the break status register, resets to 0 and is cleared by writing 0.
// - The reset cause register holds power-on, pin, watchdog, bad opcode, bad address, usb and low voltage flags in bits 7 to 1 with bit 0 reading 0.
// - The break flag control register has one read/write enable bit at bit 7 that resets to 0.
// - The low interrupt flag register shows flags 6 to 1 in bits 7 to 2, reads 0 in bits 1 and 0 and ignores writes.
// - The high interrupt flag register shows flags 14 to 7 in bits 7 to 0 and ignores writes.
// - The interrupt flag capture is sized by a parameter so it can grow to 128 sources.
// - Each reset source sets its own flag in the reset cause register when it causes a reset.
// - A power-on reset sets the power-on flag and clears every other reset cause flag.
module sir_status_regs #(
  parameter int NUM_IRQ = sir_pkg::IRQ_DOC_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic power_on_pulse,
  input wire sir_pkg::sir_reset_cause_s reset_event,
  input wire logic break_state,
  input wire logic break_wait_set,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire sir_pkg::sir_bus_req_s bus_req,
  output logic [7:0] internal_data_bus_rd_q,
  output logic crystal_clock_q,
  output logic bus_clock_q,
  output logic bus_tick_q,
  output logic break_clear_flag_enable_q,
  output logic break_wait_flag_q
);
  logic crystal_tick;
  logic bus_access;
  logic wr_access;
  logic rd_access;
  logic [7:0] rd_mux;
  logic [NUM_IRQ-1:0] irq_q;
  logic [NUM_IRQ-1:0] irq_d;
  logic [sir_pkg::IRQ_DOC_COUNT-1:0] irq_doc;
  sir_pkg::sir_reset_cause_s cause_q;
  sir_pkg::sir_reset_cause_s cause_d;
  logic break_wait_d;
  logic clear_enable_d;
  logic [7:0] rd_d;

  // crystal clock: doubled clock halved, free running in every state
  sir_clk_div #(
    .DIV(sir_pkg::DIV_CRYSTAL)
  ) u_crystal_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_q(crystal_tick),
    .square_q(crystal_clock_q)
  );

  // bus clock: doubled clock divided by four
  sir_clk_div #(
    .DIV(sir_pkg::DIV_BUS)
  ) u_bus_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_q(bus_tick_q),
    .square_q(bus_clock_q)
  );

  // access qualified by strobe in the bus clock cycle
  assign bus_access = bus_req.strobe && bus_tick_q;
  assign wr_access = bus_access && !bus_req.read_not_write;
  assign rd_access = bus_access && bus_req.read_not_write;

  // documented flags 14..1 taken from the low end of the capture
  always_comb
  begin
    irq_doc = '0;
    for (int i = 0; i < sir_pkg::IRQ_DOC_COUNT; i++)
    begin
      if (i < NUM_IRQ)
      begin
        irq_doc[i] = irq_q[i];
      end
    end
  end

  // interrupt flag capture, width set by parameter up to 128
  always_comb
  begin
    irq_d = irq_pending;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= '0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // reset cause flags; power-on has priority and clears the rest
  always_comb
  begin
    cause_d = cause_q;
    if (power_on_pulse)
    begin
      cause_d = sir_pkg::sir_reset_cause_s'(sir_pkg::RESET_CAUSE_POR);
    end
    else
    begin
      cause_d.pin = cause_q.pin | reset_event.pin;
      cause_d.watchdog = cause_q.watchdog | reset_event.watchdog;
      cause_d.bad_opcode = cause_q.bad_opcode | reset_event.bad_opcode;
      cause_d.bad_address = cause_q.bad_address | reset_event.bad_address;
      cause_d.usb = cause_q.usb | reset_event.usb;
      cause_d.low_voltage = cause_q.low_voltage | reset_event.low_voltage;
      cause_d.power_on = cause_q.power_on | reset_event.power_on;
    end
    cause_d.zero = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_q <= sir_pkg::sir_reset_cause_s'(sir_pkg::RESET_CAUSE_POR);
    end
    else
    begin
      cause_q <= cause_d;
    end
  end

  // break wait flag and clear enable; a set in the clearing cycle wins
  always_comb
  begin
    break_wait_d = break_wait_flag_q;
    clear_enable_d = break_clear_flag_enable_q;
    if (wr_access && bus_req.addr == sir_pkg::ADDR_BREAK_STATUS && !bus_req.wdata[sir_pkg::BIT_BREAK_WAIT])
    begin
      break_wait_d = 1'b0;
    end
    if (break_wait_set)
    begin
      break_wait_d = 1'b1;
    end
    if (wr_access && bus_req.addr == sir_pkg::ADDR_BREAK_FLAG_CTRL)
    begin
      clear_enable_d = bus_req.wdata[sir_pkg::BIT_CLEAR_ENABLE];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      break_wait_flag_q <= 1'b0;
      break_clear_flag_enable_q <= 1'b0;
    end
    else
    begin
      break_wait_flag_q <= break_wait_d;
      break_clear_flag_enable_q <= clear_enable_d;
    end
  end

  // read multiplexer; reserved bits and unmapped addresses read 0
  always_comb
  begin
    rd_mux = sir_pkg::BYTE_ZERO;
    unique case (bus_req.addr)
      sir_pkg::ADDR_BREAK_STATUS:
      begin
        rd_mux[sir_pkg::BIT_BREAK_WAIT] = break_wait_flag_q;
      end
      sir_pkg::ADDR_RESET_CAUSE:
      begin
        rd_mux = cause_q;
      end
      sir_pkg::ADDR_BREAK_FLAG_CTRL:
      begin
        rd_mux[sir_pkg::BIT_CLEAR_ENABLE] = break_clear_flag_enable_q;
      end
      sir_pkg::ADDR_IRQ_LOW:
      begin
        rd_mux[7:sir_pkg::IRQ_LOW_SHIFT] = irq_doc[sir_pkg::IRQ_LOW_COUNT-1:0];
      end
      sir_pkg::ADDR_IRQ_HIGH:
      begin
        rd_mux = irq_doc[sir_pkg::IRQ_DOC_COUNT-1:sir_pkg::IRQ_LOW_COUNT];
      end
      default:
      begin
        rd_mux = sir_pkg::BYTE_ZERO;
      end
    endcase
  end

  // read data held until the next read access
  always_comb
  begin
    rd_d = rd_access ? rd_mux : internal_data_bus_rd_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      internal_data_bus_rd_q <= sir_pkg::BYTE_ZERO;
    end
    else
    begin
      internal_data_bus_rd_q <= rd_d;
    end
  end

  // break state only observed; clocks above ignore it by design
  logic unused_break;
  assign unused_break = break_state & crystal_tick;
endmodule // sir_status_regs

// ### bench/sir_status_regs_sva.sv
// assertion checker for the system integration status register bank
`timescale 1ns/1ns
module sir_status_regs_sva #(
  parameter int NUM_IRQ = 14
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic break_wait_set,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire sir_pkg::sir_bus_req_s bus_req,
  input wire logic [7:0] internal_data_bus_rd_q,
  input wire logic crystal_clock_q,
  input wire logic bus_clock_q,
  input wire logic bus_tick_q,
  input wire logic break_clear_flag_enable_q,
  input wire logic break_wait_flag_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // accesses taken on a bus tick
  wire rd_tk = bus_req.strobe && bus_tick_q && bus_req.read_not_write;
  wire wr_tk = bus_req.strobe && bus_tick_q && !bus_req.read_not_write;
  AST_XTAL_RUN: assert property ($past(rst_n) |-> crystal_clock_q != $past(crystal_clock_q))
    else $error("crystal clock stalled");
  AST_TICK_DIV: assert property (bus_tick_q |=> !bus_tick_q [*3] ##1 bus_tick_q)
    else $error("bus tick not every 4");
  // bus clock low two cycles, high two cycles, tick in its second high cycle
  AST_BUS_CLK: assert property (bus_tick_q |-> bus_clock_q && $past(bus_clock_q)
    && !$past(bus_clock_q, 2) && !$past(bus_clock_q, 3)) else $error("bus clock phase wrong");
  AST_WAIT_SET: assert property (break_wait_set |=> break_wait_flag_q)
    else $error("wait flag not set");
  AST_WAIT_CLR: assert property (wr_tk && bus_req.addr == sir_pkg::ADDR_BREAK_STATUS && !bus_req.wdata[1]
    && !break_wait_set |=> !break_wait_flag_q) else $error("wait flag not cleared");
  AST_ENA_WR: assert property (wr_tk && bus_req.addr == sir_pkg::ADDR_BREAK_FLAG_CTRL
    |=> break_clear_flag_enable_q == $past(bus_req.wdata[7])) else $error("enable write wrong");
  AST_OFF_TICK: assert property (bus_req.strobe && !bus_tick_q |=> $stable(break_clear_flag_enable_q))
    else $error("access taken off tick");
  AST_IRQ_LOW: assert property (rd_tk && bus_req.addr == sir_pkg::ADDR_IRQ_LOW
    |=> internal_data_bus_rd_q == {$past(irq_pending[5:0], 2), 2'b00}) else $error("low flags wrong");
  AST_IRQ_HIGH: assert property (rd_tk && bus_req.addr == sir_pkg::ADDR_IRQ_HIGH
    |=> internal_data_bus_rd_q == $past(irq_pending[13:6], 2)) else $error("high flags wrong");
endmodule // sir_status_regs_sva

bind sir_status_regs sir_status_regs_sva #(.NUM_IRQ(NUM_IRQ)) u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .break_wait_set(break_wait_set), .irq_pending(irq_pending), .bus_req(bus_req),
  .internal_data_bus_rd_q(internal_data_bus_rd_q), .crystal_clock_q(crystal_clock_q), .bus_clock_q(bus_clock_q),
  .bus_tick_q(bus_tick_q),
  .break_clear_flag_enable_q(break_clear_flag_enable_q), .break_wait_flag_q(break_wait_flag_q));

// ### bench/sir_cpu_model.sv
// cpu core model that makes byte accesses on the internal bus
`timescale 1ns/1ns
module sir_cpu_model (
  input wire logic sys_clk,
  input wire logic bus_tick_q,
  input wire logic [7:0] rd_q,
  output sir_pkg::sir_bus_req_s bus_req
);
  initial bus_req = '0;
  // one access, held until the tick edge takes it, then released with scrambled lines
  task automatic xfer(input logic rnw, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #1 bus_req = '{1'b1, rnw, a, d};
    while (bus_tick_q !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1 q = rd_q;
    bus_req = '{1'b0, ~rnw, ~a, ~d};
  endtask
endmodule // sir_cpu_model

// ### bench/sir_status_regs_bench.sv
// self-checking bench for the system integration status register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0s expected %h seen %h", nm, e, g); end end
module sir_status_regs_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_pulse = 1'b0;
  sir_pkg::sir_reset_cause_s reset_event = '0;
  logic break_wait_set = 1'b0;
  logic [13:0] irq_pending = '0;
  logic [13:0] pat [3] = '{14'h3FFF, 14'h1555, 14'h2AAA};
  sir_pkg::sir_bus_req_s bus_req;
  logic [7:0] rd_q;
  logic [7:0] cause;
  logic tick;
  int err_total = 0;
  int total_checks = 0;
  sir_status_regs #(.NUM_IRQ(14)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .power_on_pulse(power_on_pulse),
    .reset_event(reset_event), .break_state(1'b1), .break_wait_set(break_wait_set), .irq_pending(irq_pending),
    .bus_req(bus_req), .internal_data_bus_rd_q(rd_q), .crystal_clock_q(), .bus_clock_q(), .bus_tick_q(tick),
    .break_clear_flag_enable_q(), .break_wait_flag_q());
  sir_cpu_model cpu (.sys_clk(sys_clk), .bus_tick_q(tick), .rd_q(rd_q), .bus_req(bus_req));
  // 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.xfer(1'b1, a, 8'h00, q);
    `CHK($sformatf("read %h", a), e, q)
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // main sequence, break state held throughout
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    rd(sir_pkg::ADDR_BREAK_STATUS, 8'h00);
    rd(sir_pkg::ADDR_RESET_CAUSE, 8'h80);
    rd(sir_pkg::ADDR_BREAK_FLAG_CTRL, 8'h00);
    rd(16'hFE02, 8'h00);
    cause = 8'h80;
    for (int i = 0; i < 7; i++)
    begin
      step();
      reset_event = sir_pkg::sir_reset_cause_s'(8'h01 << i);
      step();
      reset_event = '0;
      cause = cause | ((8'h01 << i) & 8'hFE);
      wr(sir_pkg::ADDR_RESET_CAUSE, 8'h00);
      rd(sir_pkg::ADDR_RESET_CAUSE, cause);
    end
    step();
    power_on_pulse = 1'b1;
    reset_event = '1;
    step();
    power_on_pulse = 1'b0;
    reset_event = '0;
    rd(sir_pkg::ADDR_RESET_CAUSE, 8'h80);
    step();
    break_wait_set = 1'b1;
    step();
    break_wait_set = 1'b0;
    wr(sir_pkg::ADDR_BREAK_STATUS, 8'hFF);
    rd(sir_pkg::ADDR_BREAK_STATUS, 8'h02);
    // set held across a clearing write: the set wins
    break_wait_set = 1'b1;
    wr(sir_pkg::ADDR_BREAK_STATUS, 8'h00);
    break_wait_set = 1'b0;
    rd(sir_pkg::ADDR_BREAK_STATUS, 8'h02);
    wr(sir_pkg::ADDR_BREAK_STATUS, 8'h00);
    rd(sir_pkg::ADDR_BREAK_STATUS, 8'h00);
    wr(sir_pkg::ADDR_BREAK_FLAG_CTRL, 8'hFF);
    rd(sir_pkg::ADDR_BREAK_FLAG_CTRL, 8'h80);
    wr(sir_pkg::ADDR_BREAK_FLAG_CTRL, 8'h7F);
    rd(sir_pkg::ADDR_BREAK_FLAG_CTRL, 8'h00);
    foreach (pat[k])
    begin
      irq_pending = pat[k];
      wr(sir_pkg::ADDR_IRQ_LOW, 8'h00);
      wr(sir_pkg::ADDR_IRQ_HIGH, 8'h00);
      rd(sir_pkg::ADDR_IRQ_LOW, {pat[k][5:0], 2'b00});
      rd(sir_pkg::ADDR_IRQ_HIGH, pat[k][13:6]);
    end
    report_and_stop();
  end
endmodule // sir_status_regs_bench
